// ===== logic/smc_defs.svh
`ifndef SMC_DEFS_SVH
`define SMC_DEFS_SVH

// ----------------------------------------------------------------
// Register map (byte offsets on the Avalon-MM slave)
// ----------------------------------------------------------------
`define SMC_ADDR_W 4
`define SMC_CTRL_OFS 4'h0
`define SMC_STAT_OFS 4'h4

// ----------------------------------------------------------------
// Control register fields and reset values
// ----------------------------------------------------------------
`define SMC_CTRL_OSC_STOP_BIT 0
`define SMC_CTRL_SEL_LSB 1
`define SMC_CTRL_SEL_MSB 2
`define SMC_CTRL_RESET 3'h0

// ----------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------
`define SMC_STAT_MODE_LSB 0
`define SMC_STAT_SEL_LSB 2
`define SMC_STAT_INT_OSC_BIT 4
`define SMC_STAT_HS_OSC_BIT 5
`define SMC_STAT_REFUSED_BIT 6
`define SMC_STAT_OPT_BIT 7

// ----------------------------------------------------------------
// Timing: core stall after stop release, in internal osc periods
// ----------------------------------------------------------------
`define SMC_WAKE_FR_PERIODS 5'h11

`endif

// ===== logic/smc_pkg.sv
package smc_pkg;

  // Standby state of the core
  typedef enum logic [1:0] {
    SMC_RUN  = 2'b00,
    SMC_HALT = 2'b01,
    SMC_STOP = 2'b10,
    SMC_WAKE = 2'b11
  } smc_mode_e;

  // Core clock source; code 2'b11 is not a source
  typedef enum logic [1:0] {
    SMC_CLK_HS  = 2'b00,
    SMC_CLK_INT = 2'b01,
    SMC_CLK_SUB = 2'b10,
    SMC_CLK_BAD = 2'b11
  } smc_clk_e;

  typedef logic [4:0] smc_cnt_t;

endpackage

// ===== logic/smc_tmr_if.sv
`timescale 1ns/1ns
// Link between the sequencer and its post-release wait timer
interface smc_tmr_if;
  logic start;
  logic tick;
  logic busy;
  logic done;
  modport ctl (output start, output tick, input busy, input done);
  modport tmr (input start, input tick, output busy, output done);
endinterface

// ===== logic/smc_wake_timer.sv
`timescale 1ns/1ns
`include "smc_defs.svh"
module smc_wake_timer (
  input wire logic clock_i,
  input wire logic arst_n_i,
  smc_tmr_if.tmr tmr
);

  smc_pkg::smc_cnt_t cnt_r;
  logic busy_r;
  logic done_r;

  // ----------------------------------------------------------------
  // Count internal oscillator periods down to zero
  // ----------------------------------------------------------------
  // Done is a one-cycle pulse in the cycle after the tick that ends the last period
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 5'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (tmr.start) begin
        cnt_r <= `SMC_WAKE_FR_PERIODS;
        busy_r <= 1'b1;
      end else if (busy_r && tmr.tick) begin
        cnt_r <= cnt_r - 5'h01;
        if (cnt_r == 5'h01) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end
      end
    end
  end

  assign tmr.busy = busy_r;
  assign tmr.done = done_r;

endmodule

// ===== logic/smc_top.sv
`timescale 1ns/1ns
`include "smc_defs.svh"
module smc_top (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic [`SMC_ADDR_W-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic osc_sw_stoppable_i,
  input wire logic halt_insn_i,
  input wire logic stop_insn_i,
  input wire logic wake_irq_i,
  input wire logic wake_reset_i,
  input wire logic fr_tick_i,
  output logic cpu_clk_en_o,
  output logic cpu_stall_o,
  output logic [1:0] cpu_clk_sel_o,
  output logic hs_osc_en_o,
  output logic int_osc_en_o,
  output logic [1:0] standby_mode_o
);

  smc_tmr_if tmr_bus ();

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  smc_pkg::smc_mode_e mode_r;
  smc_pkg::smc_mode_e mode_nxt;
  logic [2:0] ctrl_r;
  logic [1:0] sel_act_r;
  logic [1:0] sel_act_nxt;
  logic opt_r;
  logic opt_valid_r;
  logic refused_r;
  logic int_en_r;
  logic int_en_nxt;
  logic hs_en_r;
  logic cpu_en_r;
  logic stall_r;
  logic wait_r;
  logic [31:0] rdata_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire req = avs_read_i | avs_write_i;
  wire take = req & ~wait_r;
  wire hit_ctrl = (avs_address_i == `SMC_CTRL_OFS);
  wire hit_stat = (avs_address_i == `SMC_STAT_OFS);
  wire wr_ctrl = take & avs_write_i & hit_ctrl;
  wire wr_stat = take & avs_write_i & hit_stat;
  wire [1:0] wr_sel = avs_writedata_i[`SMC_CTRL_SEL_MSB:`SMC_CTRL_SEL_LSB];
  // An unused source code is refused so the core never loses its clock
  wire wr_sel_ok = (wr_sel != smc_pkg::SMC_CLK_BAD);

  // ----------------------------------------------------------------
  // Standby requests and wake-up
  // ----------------------------------------------------------------
  wire [1:0] sel_req = ctrl_r[`SMC_CTRL_SEL_MSB:`SMC_CTRL_SEL_LSB];
  wire on_sub = (sel_act_r == smc_pkg::SMC_CLK_SUB);
  wire on_int = (sel_act_r == smc_pkg::SMC_CLK_INT);
  wire stop_ok = stop_insn_i & ~halt_insn_i & ~on_sub;
  wire stop_bad = stop_insn_i & ~halt_insn_i & on_sub;
  wire wake = wake_irq_i | wake_reset_i;
  wire in_run = (mode_r == smc_pkg::SMC_RUN);
  wire enter_wait = (mode_r == smc_pkg::SMC_STOP) & wake & on_int;
  // Internal osc may be stopped only when strapped so and not feeding the core
  wire osc_stop_eff = ctrl_r[`SMC_CTRL_OSC_STOP_BIT] & opt_r & opt_valid_r;
  wire [7:0] stat_val = {opt_r, refused_r, hs_en_r, int_en_r, sel_act_r, mode_r};
  wire [31:0] rdata_sel = hit_ctrl ? {29'h0000_0000, ctrl_r} :
                          hit_stat ? {24'h00_0000, stat_val} : 32'h0000_0000;

  assign tmr_bus.start = enter_wait;
  assign tmr_bus.tick = fr_tick_i;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      smc_pkg::SMC_RUN: begin
        if (halt_insn_i) begin
          mode_nxt = smc_pkg::SMC_HALT;
        end else if (stop_ok) begin
          mode_nxt = smc_pkg::SMC_STOP;
        end
      end
      smc_pkg::SMC_HALT: begin
        if (wake) begin
          mode_nxt = smc_pkg::SMC_RUN;
        end
      end
      smc_pkg::SMC_STOP: begin
        if (wake) begin
          // Internal-osc wake waits on the post-release timer outside this block; other sources return to run at once
          mode_nxt = on_int ? smc_pkg::SMC_WAKE : smc_pkg::SMC_RUN;
        end
      end
      smc_pkg::SMC_WAKE: begin
        if (tmr_bus.done) begin
          mode_nxt = smc_pkg::SMC_RUN;
        end
      end
    endcase
  end

  // Source follows the register only while running; frozen through standby
  assign sel_act_nxt = in_run ? sel_req : sel_act_r;

  // Internal osc holds its state through stop, even if it becomes the core clock source as stop is entered; in run it is never stopped while it is the source
  assign int_en_nxt = (mode_nxt != smc_pkg::SMC_RUN) ? int_en_r :
                      ((sel_act_nxt == smc_pkg::SMC_CLK_INT) | ~osc_stop_eff);

  // ----------------------------------------------------------------
  // Strap capture after reset release
  // ----------------------------------------------------------------
  // The strap is sampled once, never through the asynchronous reset
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      opt_r <= 1'b0;
      opt_valid_r <= 1'b0;
    end else if (!opt_valid_r) begin
      opt_r <= osc_sw_stoppable_i;
      opt_valid_r <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Registers written by software
  // ----------------------------------------------------------------
  // Refused-stop flag: a new refusal wins over a write-one clear
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= `SMC_CTRL_RESET;
      refused_r <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_r[`SMC_CTRL_OSC_STOP_BIT] <= avs_writedata_i[`SMC_CTRL_OSC_STOP_BIT];
        if (wr_sel_ok) begin
          ctrl_r[`SMC_CTRL_SEL_MSB:`SMC_CTRL_SEL_LSB] <= wr_sel;
        end
      end
      if (in_run && stop_bad) begin
        refused_r <= 1'b1;
      end else if (wr_stat && avs_writedata_i[`SMC_STAT_REFUSED_BIT]) begin
        refused_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode and clock controls
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mode_r <= smc_pkg::SMC_RUN;
      sel_act_r <= 2'h0;
      int_en_r <= 1'b1;
      hs_en_r <= 1'b1;
      cpu_en_r <= 1'b1;
      stall_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      sel_act_r <= sel_act_nxt;
      int_en_r <= int_en_nxt;
      hs_en_r <= (mode_nxt != smc_pkg::SMC_STOP);
      cpu_en_r <= (mode_nxt == smc_pkg::SMC_RUN);
      stall_r <= (mode_nxt == smc_pkg::SMC_WAKE);
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait cycle, then answer
  // ----------------------------------------------------------------
  // Waitrequest idles high so no access completes before it is decoded
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wait_r <= 1'b1;
      rdata_r <= 32'h0000_0000;
    end else begin
      wait_r <= ~(req & wait_r);
      if (req & wait_r) begin
        rdata_r <= rdata_sel;
      end
    end
  end

  smc_wake_timer u_timer (
    .clock_i(clock_i),
    .arst_n_i(arst_n_i),
    .tmr(tmr_bus.tmr)
  );

  // ----------------------------------------------------------------
  // Outputs, all from flip-flops
  // ----------------------------------------------------------------
  assign avs_readdata_o = rdata_r;
  assign avs_waitrequest_o = wait_r;
  assign cpu_clk_en_o = cpu_en_r;
  assign cpu_stall_o = stall_r;
  assign cpu_clk_sel_o = sel_act_r;
  assign hs_osc_en_o = hs_en_r;
  assign int_osc_en_o = int_en_r;
  assign standby_mode_o = mode_r;

endmodule

// ===== verif/smc_checker_properties.sv
`timescale 1ns/1ns
// ------------------------------------------------
// Standby sequencer checker
// ------------------------------------------------
module smc_checker (
  input wire logic clock_i,
  input wire logic arst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic avs_waitrequest_o,
  input wire logic osc_sw_stoppable_i,
  input wire logic halt_insn_i,
  input wire logic stop_insn_i,
  input wire logic wake_irq_i,
  input wire logic wake_reset_i,
  input wire logic fr_tick_i,
  input wire logic cpu_clk_en_o,
  input wire logic cpu_stall_o,
  input wire logic [1:0] cpu_clk_sel_o,
  input wire logic hs_osc_en_o,
  input wire logic int_osc_en_o,
  input wire logic [1:0] standby_mode_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);
  // Mode decodes
  wire m_run = standby_mode_o == smc_pkg::SMC_RUN;
  wire m_halt = standby_mode_o == smc_pkg::SMC_HALT;
  wire m_stop = standby_mode_o == smc_pkg::SMC_STOP;
  wire m_wake = standby_mode_o == smc_pkg::SMC_WAKE;
  wire wake = wake_irq_i || wake_reset_i;
  logic [4:0] cnt_r;
  // Ticks seen in the wait; saturates so a stuck wait cannot wrap back to legal
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) cnt_r <= 5'h0;
    else if (!m_wake) cnt_r <= 5'h0;
    else if (fr_tick_i && cnt_r != 5'h1F) cnt_r <= cnt_r + 5'h1;
  end
  sequence s_ans;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  sequence s_stop(logic [1:0] s);
    m_run && stop_insn_i && !halt_insn_i && cpu_clk_sel_o == s;
  endsequence
  property p_bus; (avs_read_i || avs_write_i) && avs_waitrequest_o |=> s_ans; endproperty
  property p_halt; m_run && halt_insn_i |=> m_halt && !cpu_clk_en_o; endproperty
  property p_sub; s_stop(smc_pkg::SMC_CLK_SUB) |=> m_run; endproperty
  property p_int; s_stop(smc_pkg::SMC_CLK_INT) |=> m_stop && !hs_osc_en_o && int_osc_en_o;
  endproperty
  // The release edge itself may legally re-evaluate the oscillator for run mode
  property p_keep; m_stop && int_osc_en_o && !wake |=> int_osc_en_o; endproperty
  property p_wake; m_stop && wake |=>
    (cpu_clk_sel_o == smc_pkg::SMC_CLK_INT) ? (m_wake && cpu_stall_o) : m_run; endproperty
  // Window: the wait lasts at least to the cycle after the seventeenth tick and may not reach an eighteenth
  property p_min; m_wake && cnt_r < 5'h11 |=> m_wake && cpu_stall_o; endproperty
  property p_max; m_wake |-> cnt_r <= 5'h11; endproperty
  property p_res; m_halt && wake |=> m_run && cpu_clk_en_o && $stable(cpu_clk_sel_o); endproperty
  property p_strap; m_run && !osc_sw_stoppable_i |-> int_osc_en_o; endproperty
  a_bus: assert property (p_bus) else $error("bus answer not one wait");
  a_halt: assert property (p_halt) else $error("halt not entered");
  a_sub: assert property (p_sub) else $error("stop taken on sub clock");
  a_int: assert property (p_int) else $error("stop on int clock wrong");
  a_keep: assert property (p_keep) else $error("int osc stopped in stop");
  a_wake: assert property (p_wake) else $error("stop release wrong");
  a_min: assert property (p_min) else $error("wait ended early");
  a_max: assert property (p_max) else $error("wait too long");
  a_res: assert property (p_res) else $error("halt resume wrong");
  a_strap: assert property (p_strap) else $error("int osc stopped by software");
endmodule
bind smc_top smc_checker u_chk (.clock_i, .arst_n_i, .avs_read_i, .avs_write_i,
  .avs_waitrequest_o, .osc_sw_stoppable_i, .halt_insn_i, .stop_insn_i, .wake_irq_i,
  .wake_reset_i, .fr_tick_i, .cpu_clk_en_o, .cpu_stall_o, .cpu_clk_sel_o, .hs_osc_en_o,
  .int_osc_en_o, .standby_mode_o);

// ===== verif/smc_osc_model.sv
`timescale 1ns/1ns
// Internal oscillator seen by the core
module smc_osc_model (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic osc_en_i,
  output logic fr_tick_o
);
  logic [1:0] div_r;
  // One tick every third clock; a stopped oscillator gives no ticks at all
  always_ff @(posedge clock_i) begin
    div_r <= (!rst_n_i || !osc_en_i || div_r == 2'h2) ? 2'h0 : div_r + 2'h1;
    fr_tick_o <= rst_n_i && osc_en_i && div_r == 2'h2;
  end
endmodule

// ===== verif/standby_mode_control_test.sv
`timescale 1ns/1ns
module standby_mode_control_test;
  logic clk = 0;
  logic rst_n = 0;
  logic rd = 0, wr = 0, strap = 1, halt = 0, stop = 0, irq = 0, wrst = 0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, v;
  wire [31:0] rdata;
  wire wt, tick, cen, stall, hs, io;
  wire [1:0] sel, mode;
  int num_errors = 0;
  int n_compared = 0;
  always #2 clk = ~clk;
  smc_top uut (.clock_i(clk), .arst_n_i(rst_n), .avs_address_i(addr), .avs_read_i(rd),
    .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(wt), .osc_sw_stoppable_i(strap), .halt_insn_i(halt),
    .stop_insn_i(stop), .wake_irq_i(irq), .wake_reset_i(wrst), .fr_tick_i(tick),
    .cpu_clk_en_o(cen), .cpu_stall_o(stall), .cpu_clk_sel_o(sel), .hs_osc_en_o(hs),
    .int_osc_en_o(io), .standby_mode_o(mode));
  smc_osc_model u_osc (.clock_i(clk), .rst_n_i(rst_n), .osc_en_i(io), .fr_tick_o(tick));
  // ------------------------------------------------
  // Tasks
  // ------------------------------------------------
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  // Avalon access; the extra edges let the register's effect reach the outputs
  task acc(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    do @(posedge clk); while (wt !== 1'b0);
    v = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // One-cycle pulse on halt, stop, irq or reset-input; 4 pulses halt and stop together
  task ins(input int k);
    @(posedge clk);
    {halt, stop, irq, wrst} <= (k == 4) ? 4'hC : 4'h8 >> k;
    @(posedge clk);
    {halt, stop, irq, wrst} <= 4'h0;
    repeat (2) @(posedge clk);
  endtask
  task stop_test;
    $display("Errors %0d of %0d compared", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    stop_test;
  end
  // ------------------------------------------------
  // Tests
  // ------------------------------------------------
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    acc(0, 4'h0, 0); chk("ctrl", v, 32'h0);
    acc(0, 4'h4, 0); chk("status", v, 32'hB0);
    acc(1, 4'h8, 32'hFF); acc(0, 4'h8, 0); chk("unmapped", v, 32'h0);
    acc(1, 4'h0, 32'h1); chk("int_osc", io, 1'b0);
    acc(1, 4'h0, 32'h3); chk("int_osc", io, 1'b1);
    // Source code 3 is refused: select keeps its old value, stop bit still written
    acc(1, 4'h0, 32'h6); acc(0, 4'h0, 0); chk("sel code 3", v, 32'h2);
    for (int s = 0; s < 3; s++) begin
      acc(1, 4'h0, s << 1);
      ins(0); chk("halt mode", mode, 2'h1);
      chk("clk_en", cen, 1'b0);
      ins(2); chk("sel", sel, s);
      chk("run", {cen, mode}, 3'h4);
    end
    acc(1, 4'h0, 32'h4);
    // Halt and stop in one cycle: halt wins, and no refusal is flagged
    ins(4); chk("halt first", mode, 2'h1);
    ins(2); chk("halt first run", mode, 2'h0);
    ins(1); chk("sub stop", mode, 2'h0);
    acc(0, 4'h4, 0); chk("refused", v[6], 1'b1);
    acc(1, 4'h4, 32'h40); acc(0, 4'h4, 0); chk("refused", v[6], 1'b0);
    acc(1, 4'h0, 32'h0);
    // Bench drives no peripherals or converter, so stop may go at once
    ins(1); chk("hs stop", {mode, hs, io}, 4'h9);
    ins(3); chk("hs wake", {mode, hs, cen}, 4'h3);
    acc(1, 4'h0, 32'h3);
    ins(1); chk("int stop", {mode, hs, io}, 4'h9);
    ins(2); chk("wake", {mode, stall}, 3'h7);
    repeat (30) @(posedge clk); chk("stall", stall, 1'b1);
    repeat (50) @(posedge clk); chk("resume", {mode, stall, cen}, 4'h1);
    rst_n <= 1'b0;
    strap <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    acc(1, 4'h0, 32'h1); chk("fixed osc", io, 1'b1);
    acc(0, 4'h4, 0); chk("strap", v[7], 1'b0);
    stop_test;
  end
endmodule
